// File: logic/valve_cfg_regs.sv
`timescale 1ns/1ps
// Overview of operation
// RL1: parity bit 15, identifier bits 14:10
// RL2: response bit 14 flags previous bad frame
// RL3: message one bits 9:6 proportional gain code
// RL4: message one bits 5:3 integral gain code
// RL5: message one bit 2 disables sink current
// RL6: message one reply: trace code, gain echo
// RL7: message three bits 5:4 modulation band, enable
// RL8: message three bit 3 disables clock monitor
// RL9: message three reply: count and supply faults
// RL10: message four bit 7 integrator clamp
// RL11: message four bit 6 edge rate
// RL12: message four bit 5 first duty limit
// RL13: message four bits 4:3 minimum duty mode
// RL14: message four bit 2 feedback source
// RL15: message four bits 1:0 pwm pairs
// RL16: message four reply: pump oc, echo, adc
// RL17: message five bits 1:0 driver enables
// RL18: message five reply: regulation errors, adc
// RL19: message six bits clear latched faults
// RL20: message six reply: driver a flags, adc
// RL21: message seven reply: driver b flags
// RL22: drop frames not 16 bits or odd parity
// RL23: clear acts one clock, then self-clears
// RL24: faults double buffered, outer on frame end
// RL25: reserved message ignored, replies zero data
module valve_cfg_regs #(
  parameter int ADC_W = 10,
  parameter logic [3:0] TRACE_CODE = 4'h5 // arbitrary value
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic csb_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic [valve_cfg_pkg::NFAULT-1:0] fault_in,
  input wire logic [7:0] clock_monitor_count,
  input wire logic [ADC_W-1:0] vint_a_adc,
  input wire logic [ADC_W-1:0] vint_d_adc,
  input wire logic [ADC_W-1:0] prereg_10v_adc,
  input wire logic [ADC_W-1:0] prereg_12v_adc,
  output logic [3:0] p_gain_code,
  output logic [2:0] i_gain_code,
  output logic sink_disable,
  output logic modulation_band_select,
  output logic modulation_enable,
  output logic clock_monitor_disable,
  output logic integrator_clamp_wide,
  output logic fast_edge_rate,
  output logic first_duty_limit,
  output logic [1:0] min_duty_mode,
  output logic feedback_source_select,
  output logic pwm_mode_pair_a,
  output logic pwm_mode_pair_b,
  output logic gp_driver_b_on,
  output logic gp_driver_a_on,
  output logic gp_driver_b_fault_clear,
  output logic gp_driver_a_fault_clear,
  output logic pump_fault_clear,
  output logic valve_fault_clear
);

  // response fields are laid out for ten-bit converters only
  if (ADC_W != 10) begin : g_bad_width
    $error("valve_cfg_regs: ADC_W must be 10");
  end

  // ---------------- link side, on sclk ----------------
  logic [15:0] rx_shift; // last sixteen bits seen on mosi
  logic [5:0] cnt_bin; // free-running count of sclk rises
  logic [5:0] cnt_gray; // gray copy handed to mclk
  logic [3:0] frame_pos; // rises since chip select fell
  logic launched; // first falling edge of frame seen
  logic tx_bit; // bit presented after a falling edge
  logic [15:0] tx_word; // reply prepared in the mclk domain
  logic [5:0] next_cnt_bin;
  wire logic [3:0] tx_idx;

  assign next_cnt_bin = 6'(cnt_bin + 6'h01);
  assign tx_idx = 4'hF - frame_pos;

  // sample mosi and count pulses on every rising edge
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      rx_shift <= 16'h0000;
      cnt_bin <= 6'h00;
      cnt_gray <= 6'h00;
    end else begin
      rx_shift <= {rx_shift[14:0], mosi};
      cnt_bin <= next_cnt_bin;
      cnt_gray <= next_cnt_bin ^ (next_cnt_bin >> 1);
    end
  end

  // frame position is ended by chip select itself
  always_ff @(posedge sclk or posedge csb_n) begin
    if (csb_n) begin
      frame_pos <= 4'h0;
    end else begin
      frame_pos <= 4'(frame_pos + 4'h1);
    end
  end

  // shift the reply out on falling edges; tx_word holds still through the frame
  always_ff @(negedge sclk or posedge csb_n) begin
    if (csb_n) begin
      launched <= 1'b0;
      tx_bit <= 1'b0;
    end else begin
      launched <= 1'b1;
      tx_bit <= tx_word[tx_idx];
    end
  end

  // msb is shown before the first edge, later bits from the shifter
  assign miso = launched ? tx_bit : tx_word[valve_cfg_pkg::PAR_BIT];

  // ---------------- core side, on mclk ----------------
  logic csb_s1, csb_s2, csb_d; // chip select synchroniser
  logic [5:0] gray_s1, gray_s2; // pulse count synchroniser
  logic [15:0] rx_s1, rx_s2; // frame word, quiet once csb is high
  logic [5:0] base_bin; // pulse count at previous frame end
  logic resp_stb; // cycle after a frame end
  logic ok_q; // last frame was accepted
  logic [4:0] id_q; // identifier of last frame, zero if it was refused
  logic [valve_cfg_pkg::NFAULT-1:0] fault_s1, fault_s2, inner, outer;
  logic [5:0] cur_bin;

  // gray count back to binary
  always_comb begin
    cur_bin = 6'h00;
    cur_bin[5] = gray_s2[5];
    for (int i = 4; i >= 0; i--) begin
      cur_bin[i] = cur_bin[i+1] ^ gray_s2[i];
    end
  end

  wire logic frame_end = csb_s2 & ~csb_d;
  wire logic [5:0] nbits = 6'(cur_bin - base_bin);
  wire logic frame_ok = (nbits == valve_cfg_pkg::FRAME_LEN) && !(^rx_s2); // [RL22]
  wire logic [4:0] rx_id = rx_s2[valve_cfg_pkg::ID_HI:valve_cfg_pkg::ID_LO]; // [RL1]
  wire logic wr = frame_end & frame_ok;
  wire logic [9:0] pay = rx_s2[9:0];

  // synchronise chip select, count and word
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      csb_s1 <= 1'b1;
      csb_s2 <= 1'b1;
      csb_d <= 1'b1;
      gray_s1 <= 6'h00;
      gray_s2 <= 6'h00;
      rx_s1 <= 16'h0000;
      rx_s2 <= 16'h0000;
    end else begin
      csb_s1 <= csb_n;
      csb_s2 <= csb_s1;
      csb_d <= csb_s2;
      gray_s1 <= cnt_gray;
      gray_s2 <= gray_s1;
      rx_s1 <= rx_shift;
      rx_s2 <= rx_s1;
    end
  end

  // frame bookkeeping and output enable
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      base_bin <= 6'h00;
      resp_stb <= 1'b0;
      ok_q <= 1'b1;
      id_q <= 5'h00;
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= ~csb_s2;
      resp_stb <= frame_end;
      if (frame_end) begin
        base_bin <= cur_bin;
        ok_q <= frame_ok; // [RL2]
        id_q <= frame_ok ? rx_id : 5'h00;
      end
    end
  end

  // configuration registers, written only by accepted frames
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      p_gain_code <= 4'h0;
      i_gain_code <= 3'h0;
      sink_disable <= 1'b0;
      modulation_band_select <= 1'b0;
      modulation_enable <= 1'b0;
      clock_monitor_disable <= 1'b0;
      integrator_clamp_wide <= 1'b0;
      fast_edge_rate <= 1'b0;
      first_duty_limit <= 1'b0;
      min_duty_mode <= 2'h0;
      feedback_source_select <= 1'b0;
      pwm_mode_pair_a <= 1'b0;
      pwm_mode_pair_b <= 1'b0;
      gp_driver_b_on <= 1'b0;
      gp_driver_a_on <= 1'b0;
    end else if (wr) begin
      // reserved identifier falls through untouched [RL25]
      if (rx_id == valve_cfg_pkg::ID_GAIN) begin
        p_gain_code <= pay[valve_cfg_pkg::GAIN_P_LO +: 4]; // [RL3]
        i_gain_code <= pay[valve_cfg_pkg::GAIN_I_LO +: 3]; // [RL4]
        sink_disable <= pay[valve_cfg_pkg::SINK_BIT]; // [RL5]
      end
      if (rx_id == valve_cfg_pkg::ID_CLOCK) begin
        modulation_band_select <= pay[valve_cfg_pkg::FM_BAND_BIT]; // [RL7]
        modulation_enable <= pay[valve_cfg_pkg::MOD_EN_BIT]; // [RL7]
        clock_monitor_disable <= pay[valve_cfg_pkg::CLKMON_BIT]; // [RL8]
      end
      if (rx_id == valve_cfg_pkg::ID_MODE) begin
        integrator_clamp_wide <= pay[valve_cfg_pkg::ICLAMP_BIT]; // [RL10]
        fast_edge_rate <= pay[valve_cfg_pkg::DIDT_BIT]; // [RL11]
        first_duty_limit <= pay[valve_cfg_pkg::FIRST_DUTY_BIT]; // [RL12]
        min_duty_mode <= pay[valve_cfg_pkg::MIN_DUTY_LO +: 2]; // [RL13]
        feedback_source_select <= pay[valve_cfg_pkg::FB_BIT]; // [RL14]
        pwm_mode_pair_a <= pay[valve_cfg_pkg::PAIR_A_BIT]; // [RL15]
        pwm_mode_pair_b <= pay[valve_cfg_pkg::PAIR_B_BIT]; // [RL15]
      end
      if (rx_id == valve_cfg_pkg::ID_GPEN) begin
        gp_driver_b_on <= pay[valve_cfg_pkg::GPB_ON_BIT]; // [RL17]
        gp_driver_a_on <= pay[valve_cfg_pkg::GPA_ON_BIT]; // [RL17]
      end
    end
  end

  // clear pulses last exactly one clock after the frame
  wire logic clr_wr = wr && (rx_id == valve_cfg_pkg::ID_CLEAR);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gp_driver_b_fault_clear <= 1'b0;
      gp_driver_a_fault_clear <= 1'b0;
      pump_fault_clear <= 1'b0;
      valve_fault_clear <= 1'b0;
    end else begin
      gp_driver_b_fault_clear <= clr_wr & pay[valve_cfg_pkg::CLR_GPB_BIT]; // [RL19] [RL23]
      gp_driver_a_fault_clear <= clr_wr & pay[valve_cfg_pkg::CLR_GPA_BIT]; // [RL19] [RL23]
      pump_fault_clear <= clr_wr & pay[valve_cfg_pkg::CLR_PUMP_BIT]; // [RL19] [RL23]
      valve_fault_clear <= clr_wr & pay[valve_cfg_pkg::CLR_VALVE_BIT]; // [RL19] [RL23]
    end
  end

  // faults dropped by a clear pulse, and faults just reported
  wire logic [17:0] clr_vec = ({18{gp_driver_b_fault_clear}} & valve_cfg_pkg::MASK_CLR_GPB)
                            | ({18{gp_driver_a_fault_clear}} & valve_cfg_pkg::MASK_CLR_GPA)
                            | ({18{pump_fault_clear}} & valve_cfg_pkg::MASK_CLR_PUMP);
  wire logic [17:0] msg_mask = (id_q == valve_cfg_pkg::ID_CLOCK) ? valve_cfg_pkg::MASK_M3 :
                               (id_q == valve_cfg_pkg::ID_MODE) ? valve_cfg_pkg::MASK_M4 :
                               (id_q == valve_cfg_pkg::ID_GPEN) ? valve_cfg_pkg::MASK_M5 :
                               (id_q == valve_cfg_pkg::ID_CLEAR) ? valve_cfg_pkg::MASK_M6 :
                               (id_q == valve_cfg_pkg::ID_GPB) ? valve_cfg_pkg::MASK_M7 : 18'h0_0000;
  wire logic [17:0] rel_vec = (resp_stb && ok_q) ? msg_mask : 18'h0_0000;

  // per-fault synchroniser, inner latch and outer latch
  for (genvar f = 0; f < valve_cfg_pkg::NFAULT; f++) begin : g_fault
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        fault_s1[f] <= 1'b0;
        fault_s2[f] <= 1'b0;
        inner[f] <= 1'b0;
        outer[f] <= 1'b0;
      end else begin
        fault_s1[f] <= fault_in[f];
        fault_s2[f] <= fault_s1[f];
        // a live fault wins over clear and release [RL24]
        inner[f] <= fault_s2[f] | (inner[f] & ~clr_vec[f] & ~rel_vec[f]);
        if (frame_end) begin
          outer[f] <= inner[f]; // [RL24]
        end
      end
    end
  end

  // reply data per message
  wire logic [13:0] d_m1 = {TRACE_CODE, p_gain_code, i_gain_code, sink_disable, 2'h0}; // [RL6]
  wire logic [13:0] d_m3 = {clock_monitor_count, outer[valve_cfg_pkg::F_OV], 1'b0,
                            outer[valve_cfg_pkg::F_UV], outer[valve_cfg_pkg::F_GND],
                            outer[valve_cfg_pkg::F_WARN], outer[valve_cfg_pkg::F_PDOT]}; // [RL9]
  wire logic [13:0] d_m4 = {outer[valve_cfg_pkg::F_PDOC], feedback_source_select,
                            pwm_mode_pair_a, pwm_mode_pair_b, vint_a_adc}; // [RL16]
  wire logic [13:0] d_m5 = {outer[valve_cfg_pkg::F_CRER_LO +: 4], vint_d_adc}; // [RL18]
  wire logic [13:0] d_m6 = {outer[valve_cfg_pkg::F_GPA_LO +: 4], prereg_10v_adc}; // [RL20]
  wire logic [13:0] d_m7 = {outer[valve_cfg_pkg::F_GPB_LO +: 4], prereg_12v_adc}; // [RL21]
  wire logic [13:0] d_sel = (id_q == valve_cfg_pkg::ID_GAIN) ? d_m1 :
                            (id_q == valve_cfg_pkg::ID_CLOCK) ? d_m3 :
                            (id_q == valve_cfg_pkg::ID_MODE) ? d_m4 :
                            (id_q == valve_cfg_pkg::ID_GPEN) ? d_m5 :
                            (id_q == valve_cfg_pkg::ID_CLEAR) ? d_m6 :
                            (id_q == valve_cfg_pkg::ID_GPB) ? d_m7 : 14'h0000; // [RL25]
  wire logic fmsg = ~ok_q; // [RL2]
  wire logic [13:0] d_out = ok_q ? d_sel : 14'h0000;
  wire logic [15:0] resp_word = {^{fmsg, d_out}, fmsg, d_out}; // [RL1]

  // reply register, loaded once per frame end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx_word <= valve_cfg_pkg::TX_RESET;
    end else if (resp_stb) begin
      tx_word <= resp_word;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_clear_pulse;
    !pump_fault_clear ##1 pump_fault_clear ##1 !pump_fault_clear;
  endsequence

  chk_bad_frame_reply: assert property (frame_end && !frame_ok |-> ##2 tx_word == 16'hC000) // [RL22]
    else $error("rejected frame did not give error reply");
  chk_fmsg_clear: assert property (resp_stb && ok_q |=> !tx_word[valve_cfg_pkg::FMSG_BIT]) // [RL2]
    else $error("error bit set after good frame");
  chk_parity_even: assert property (resp_stb |=> !(^tx_word)) // [RL1]
    else $error("reply parity is odd");
  chk_gain_write: assert property (wr && rx_id == valve_cfg_pkg::ID_GAIN |=> p_gain_code == $past(pay[9:6])) // [RL3]
    else $error("gain code not stored");
  chk_clear_once: assert property (clr_wr && pay[valve_cfg_pkg::CLR_PUMP_BIT] |-> s_clear_pulse) // [RL23]
    else $error("pump clear pulse wrong");
  chk_outer_capture: assert property (frame_end |=> outer == $past(inner)) // [RL24]
    else $error("outer latch missed inner");
  chk_mode_echo: assert property (resp_stb && ok_q && id_q == valve_cfg_pkg::ID_MODE
    |=> tx_word[12:10] == {feedback_source_select, pwm_mode_pair_a, pwm_mode_pair_b}) // [RL16]
    else $error("mode echo wrong");
  chk_reserved_zero: assert property (resp_stb && ok_q && id_q == valve_cfg_pkg::ID_RSVD
    |=> tx_word[13:0] == 14'h0000) // [RL25]
    else $error("reserved reply not zero");
  chk_gp_enable: assert property (wr && rx_id == valve_cfg_pkg::ID_GPEN
    |=> gp_driver_a_on == $past(pay[0]) && gp_driver_b_on == $past(pay[1])) // [RL17]
    else $error("driver enables not stored");
  chk_valve_pulse: assert property (clr_wr && pay[valve_cfg_pkg::CLR_VALVE_BIT] |=> valve_fault_clear) // [RL19]
    else $error("valve clear pulse missing");

endmodule // valve_cfg_regs

// File: inc/valve_cfg_pkg.sv
package valve_cfg_pkg;
  // frame layout
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 6;
  localparam logic [5:0] FRAME_LEN = 6'h10;
  localparam int PAR_BIT = 15;
  localparam int FMSG_BIT = 14;
  localparam int ID_HI = 14;
  localparam int ID_LO = 10;
  localparam int DATA_W = 14;
  // message identifiers
  localparam logic [4:0] ID_GAIN = 5'h01;
  localparam logic [4:0] ID_RSVD = 5'h02;
  localparam logic [4:0] ID_CLOCK = 5'h03;
  localparam logic [4:0] ID_MODE = 5'h04;
  localparam logic [4:0] ID_GPEN = 5'h05;
  localparam logic [4:0] ID_CLEAR = 5'h06;
  localparam logic [4:0] ID_GPB = 5'h07;
  // gain message fields
  localparam int GAIN_P_LO = 6;
  localparam int GAIN_I_LO = 3;
  localparam int SINK_BIT = 2;
  // clock message fields
  localparam int FM_BAND_BIT = 5;
  localparam int MOD_EN_BIT = 4;
  localparam int CLKMON_BIT = 3;
  // mode message fields
  localparam int ICLAMP_BIT = 7;
  localparam int DIDT_BIT = 6;
  localparam int FIRST_DUTY_BIT = 5;
  localparam int MIN_DUTY_LO = 3;
  localparam int FB_BIT = 2;
  localparam int PAIR_A_BIT = 1;
  localparam int PAIR_B_BIT = 0;
  // driver enable and fault clear fields
  localparam int GPB_ON_BIT = 1;
  localparam int GPA_ON_BIT = 0;
  localparam int CLR_GPB_BIT = 3;
  localparam int CLR_GPA_BIT = 2;
  localparam int CLR_PUMP_BIT = 1;
  localparam int CLR_VALVE_BIT = 0;
  // fault vector positions
  localparam int NFAULT = 18;
  localparam int F_OV = 0;
  localparam int F_UV = 1;
  localparam int F_GND = 2;
  localparam int F_WARN = 3;
  localparam int F_PDOT = 4;
  localparam int F_PDOC = 5;
  localparam int F_CRER_LO = 6;
  localparam int F_GPA_LO = 10;
  localparam int F_GPB_LO = 14;
  // faults reported by each message
  localparam logic [17:0] MASK_M3 = 18'h0_001F;
  localparam logic [17:0] MASK_M4 = 18'h0_0020;
  localparam logic [17:0] MASK_M5 = 18'h0_03C0;
  localparam logic [17:0] MASK_M6 = 18'h0_3C00;
  localparam logic [17:0] MASK_M7 = 18'h3_C000;
  // faults dropped by the gp b, gp a and pump clear bits
  localparam logic [17:0] MASK_CLR_GPB = 18'h2_8000;
  localparam logic [17:0] MASK_CLR_GPA = 18'h0_2800;
  localparam logic [17:0] MASK_CLR_PUMP = 18'h0_0020;
  // response words
  localparam logic [15:0] TX_RESET = 16'hAAAA;
endpackage

// File: tb/spi_host_model.sv
`timescale 1ns/1ps
// host end of the link: msb-first frames, clock idle low between frames
module spi_host_model (
  output logic sclk,
  output logic csb_n,
  output logic mosi,
  input wire logic miso
);
  localparam realtime HALF = 62.5; // 125 ns link clock
  initial begin
    sclk = 1'b0;
    csb_n = 1'b1;
    mosi = 1'b0;
  end
  // one frame; npulse other than 16 makes a broken frame
  task automatic xfer(input logic [15:0] tx, input int npulse, output logic [15:0] rx);
    rx = 16'h0000;
    #(17); // phase offset from the core clock
    csb_n = 1'b0;
    for (int k = 0; k < npulse; k++) begin
      mosi = tx[15-k]; // parity, identifier, payload
      #(HALF);
      sclk = 1'b1; // reply bit taken on the rising edge
      rx[15-k] = miso;
      #(HALF);
      sclk = 1'b0;
    end
    #(HALF);
    csb_n = 1'b1; // npulse pulses per frame, sixteen for a whole frame
    mosi = ~mosi; // released line shows no stale level
    #(8*HALF); // idle gap above 300 ns
  endtask
endmodule // spi_host_model

// File: tb/test_valve_ctrl_spi_config_status_msgs.sv
`timescale 1ns/1ps
// self-checking bench: host frames in, levels and replies judged here
module test_valve_ctrl_spi_config_status_msgs;
  localparam logic [3:0] TRC = 4'h9; // arbitrary trace code
  logic mclk, rstn, sclk, csb_n, mosi, miso, miso_oe;
  logic [17:0] fault_in; // raw fault levels
  logic [7:0] clock_monitor_count;
  logic [9:0] vint_a_adc, vint_d_adc, prereg_10v_adc, prereg_12v_adc;
  logic [3:0] p_gain_code;
  logic [2:0] i_gain_code;
  logic [1:0] min_duty_mode;
  logic sink_disable, modulation_band_select, modulation_enable, clock_monitor_disable;
  logic integrator_clamp_wide, fast_edge_rate, first_duty_limit, feedback_source_select;
  logic pwm_mode_pair_a, pwm_mode_pair_b, gp_driver_b_on, gp_driver_a_on;
  logic gp_driver_b_fault_clear, gp_driver_a_fault_clear, pump_fault_clear, valve_fault_clear;
  logic [15:0] rx; // last reply
  int n_errors = 0;
  int comparisons = 0;
  int pulses [4] = '{0, 0, 0, 0}; // clear pulse cycles: gp b, gp a, pump, valve
  int seen [4] = '{0, 0, 0, 0}; // pulse counts already judged
  logic oe_seen; // output enable at the last sclk rise of a frame
  wire [7:0] mode_cfg = {integrator_clamp_wide, fast_edge_rate, first_duty_limit, min_duty_mode,
    feedback_source_select, pwm_mode_pair_a, pwm_mode_pair_b};

  valve_cfg_regs #(.TRACE_CODE(TRC)) DUT (
    .mclk, .rstn, .sclk, .csb_n, .mosi, .miso, .miso_oe, .fault_in, .clock_monitor_count,
    .vint_a_adc, .vint_d_adc, .prereg_10v_adc, .prereg_12v_adc, .p_gain_code, .i_gain_code,
    .sink_disable, .modulation_band_select, .modulation_enable, .clock_monitor_disable,
    .integrator_clamp_wide, .fast_edge_rate, .first_duty_limit, .min_duty_mode,
    .feedback_source_select, .pwm_mode_pair_a, .pwm_mode_pair_b, .gp_driver_b_on,
    .gp_driver_a_on, .gp_driver_b_fault_clear, .gp_driver_a_fault_clear, .pump_fault_clear,
    .valve_fault_clear
  );
  spi_host_model host (.sclk, .csb_n, .mosi, .miso);

  // core clock, 50 ns
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // output enable as seen in mid frame
  always @(posedge sclk) begin
    oe_seen <= miso_oe;
  end
  // count cycles each clear pulse stands, away from the launching edge
  always @(negedge mclk) begin
    pulses[0] += gp_driver_b_fault_clear;
    pulses[1] += gp_driver_a_fault_clear;
    pulses[2] += pump_fault_clear;
    pulses[3] += valve_fault_clear;
  end

  // even-parity write word
  function automatic logic [15:0] frm(input logic [4:0] id, input logic [9:0] pay);
    frm = {^{id, pay}, id, pay};
  endfunction
  // expected reply word
  function automatic logic [15:0] rsp(input logic err, input logic [13:0] dat);
    rsp = {^{err, dat}, err, dat};
  endfunction
  // reply word compare
  task automatic check_reply(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // level output compare
  task automatic check_level(input logic [9:0] got, input logic [9:0] exp);
    check_reply({6'h00, got}, {6'h00, exp});
  endtask
  // one frame sent at a falling core edge
  task automatic send(input logic [15:0] w, input int n);
    @(negedge mclk);
    host.xfer(w, n, rx);
  endtask
  // each clear line pulsed exactly once where expected
  task automatic check_pulses(input logic [3:0] exp);
    for (int k = 0; k < 4; k++) begin
      check_level(10'(pulses[k] - seen[k]), 10'(exp[3-k]));
      seen[k] = pulses[k];
    end
  endtask

  // reset levels, first reply, gain echo, every gain and duty code
  task automatic test_gain;
    check_level(10'({p_gain_code, i_gain_code, sink_disable}), 10'h000);
    send(frm(5'h01, 10'h1E6), 16);
    check_reply(rx, 16'hAAAA);
    check_level(10'({oe_seen, miso_oe}), 10'h002);
    check_level(10'({p_gain_code, i_gain_code, sink_disable}), 10'h079);
    send(frm(5'h01, 10'h000), 16);
    check_reply({3'h0, rx[14:2]}, {3'h0, 1'b0, TRC, 8'h79});
    for (int c = 0; c < 16; c++) begin
      send(frm(5'h01, {4'(c), 3'(c), c[0], 2'b10}), 16);
      check_level(10'({p_gain_code, i_gain_code, sink_disable}), 10'({4'(c), 3'(c), c[0]}));
      send(frm(5'h04, {5'h00, 2'(c), 3'h0}), 16);
      check_level(10'(mode_cfg), {5'h00, 2'(c), 3'h0});
    end
  endtask
  // modulation and monitor bits, status reply
  task automatic test_clock;
    @(negedge mclk);
    fault_in = 18'h0_0015;
    clock_monitor_count = 8'hA5;
    send(frm(5'h03, 10'h038), 16);
    check_level(10'({modulation_band_select, modulation_enable, clock_monitor_disable}), 10'h007);
    send(frm(5'h03, 10'h010), 16);
    check_reply({2'h0, rx[14:5], rx[3:0]}, {3'h0, 8'hA5, 1'b1, 4'b0101});
    check_level(10'({modulation_band_select, modulation_enable, clock_monitor_disable}), 10'h002);
  endtask
  // regulation mode bits, held pump fault released after report
  task automatic test_mode;
    @(negedge mclk);
    fault_in = 18'h0_0020;
    vint_a_adc = 10'h2C3;
    repeat (2) @(negedge mclk);
    fault_in = 18'h0_0000;
    send(frm(5'h04, 10'h0FF), 16);
    check_level(10'(mode_cfg), 10'h0FF);
    send(frm(5'h04, 10'h00A), 16);
    check_level(10'(mode_cfg), 10'h00A);
    check_reply(rx, rsp(1'b0, {1'b1, 3'b111, 10'h2C3}));
    send(frm(5'h07, 10'h000), 16);
    check_reply(rx, rsp(1'b0, {1'b0, 3'b010, 10'h2C3}));
  endtask
  // driver enables and regulation error reply
  task automatic test_gp;
    @(negedge mclk);
    fault_in = 18'h0_0240;
    vint_d_adc = 10'h155;
    send(frm(5'h05, 10'h002), 16);
    check_level(10'({gp_driver_b_on, gp_driver_a_on}), 10'h002);
    send(frm(5'h05, 10'h001), 16);
    check_level(10'({gp_driver_b_on, gp_driver_a_on}), 10'h001);
    check_reply(rx, rsp(1'b0, {4'b1001, 10'h155}));
  endtask
  // clear pulses, live faults survive a clear
  task automatic test_clear;
    @(negedge mclk);
    fault_in = 18'h0_2C00;
    prereg_10v_adc = 10'h3C1;
    send(frm(5'h06, 10'h00F), 16);
    check_pulses(4'hF);
    send(frm(5'h06, 10'h004), 16);
    check_pulses(4'h4);
    check_reply(rx, rsp(1'b0, {4'b1011, 10'h3C1}));
    send(frm(5'h07, 10'h000), 16);
    check_reply(rx, rsp(1'b0, {4'b1011, 10'h3C1}));
  endtask
  // second driver status, zero payload
  task automatic test_gpb;
    @(negedge mclk);
    fault_in = 18'h1_8000;
    prereg_12v_adc = 10'h0F0;
    send(frm(5'h07, 10'h000), 16);
    send(frm(5'h07, 10'h000), 16);
    check_reply(rx, rsp(1'b0, {4'b0110, 10'h0F0}));
  endtask
  // bad parity, short frame, reserved message
  task automatic test_refuse;
    send(frm(5'h01, 10'h0C0) ^ 16'h8000, 16);
    check_level(10'(p_gain_code), 10'h00F);
    send(frm(5'h01, 10'h080), 15);
    check_reply(rx, 16'hC000);
    check_level(10'(p_gain_code), 10'h00F);
    send(frm(5'h02, 10'h3FF), 16);
    check_reply(rx, 16'hC000);
    send(frm(5'h07, 10'h000), 16);
    check_reply(rx, 16'h0000);
  endtask

  // verdict and end of run
  task automatic tally_and_finish;
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rstn = 1'b0;
    fault_in = 18'h0_0000;
    clock_monitor_count = 8'h00;
    vint_a_adc = 10'h000;
    vint_d_adc = 10'h000;
    prereg_10v_adc = 10'h000;
    prereg_12v_adc = 10'h000;
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
    repeat (4) @(negedge mclk);
    test_gain();
    test_clock();
    test_mode();
    test_gp();
    test_clear();
    test_gpb();
    test_refuse();
    tally_and_finish();
  end
  // hang guard, about three times the expected run
  initial begin
    #400us;
    n_errors++;
    tally_and_finish();
  end
endmodule // test_valve_ctrl_spi_config_status_msgs
